/* File: hdl/qca_pkg.sv */
package qca_pkg;
	localparam int unsigned clk_hz = 10000000;
	// apb register byte offsets
	localparam logic [7:0] reg_ctrl = 8'h00;
	localparam logic [7:0] reg_ampl = 8'h04;
	localparam logic [7:0] reg_limit = 8'h08;
	localparam logic [7:0] reg_status = 8'h0c;
	localparam logic [7:0] reg_interval = 8'h10;
	// control field positions
	localparam int ctrl_enable_bit = 0;
	localparam int ctrl_autoscale_bit = 1;
	localparam int ctrl_freq_lsb = 2;
	localparam int ctrl_blank_lsb = 4;
	// reset values
	localparam logic [7:0] offset_reset = 8'hff;
	localparam logic [7:0] gradient_reset = 8'h04;
	localparam logic [19:0] limit_reset = 20'h00000;
	localparam logic [19:0] interval_max = 20'hfffff;
	// pwm periods in clocks for divider codes 0..3 (half of 1024,683,512,410)
	localparam logic [9:0] period_0 = 10'h200;
	localparam logic [9:0] period_1 = 10'h156;
	localparam logic [9:0] period_2 = 10'h100;
	localparam logic [9:0] period_3 = 10'h0cd;
	localparam logic [7:0] scale_max = 8'hff;
	typedef struct packed {
		logic [1:0] blank_time_select;
		logic [1:0] chopper_frequency_divider;
		logic autoscale;
		logic enable;
	} qca_ctrl_t;
	typedef struct packed {
		logic [7:0] amplitude_gradient;
		logic [7:0] amplitude_offset;
	} qca_ampl_t;
endpackage

/* File: hdl/qca_interval.sv */
`timescale 1ns/1ns
`default_nettype none
module qca_interval #(
	parameter int W = 20
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// step pulse, already synchronous
	input wire logic step_pulse,
	// measured interval
	output logic [W-1:0] step_interval
);
	logic [W-1:0] count;
	logic [W-1:0] next_count;
	logic [W-1:0] next_interval;
	always_comb begin
		next_count = count;
		next_interval = step_interval;
		if (step_pulse) begin
			next_interval = count;
			next_count = {{(W-1){1'b0}}, 1'b1};
		end else if (count != {W{1'b1}}) begin
			next_count = count + 1'b1;
		end else begin
			next_interval = count;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '1;
			step_interval <= '1;
		end else begin
			count <= next_count;
			step_interval <= next_interval;
		end
	end
endmodule
`default_nettype wire

/* File: hdl/qca_top.sv */
// Functional notes
// - fixed mode: offset plus gradient times velocity
// - velocity from clocks between two steps
// - amplitude is 8 bit, peak 255
// - quiet chopper only at or below velocity limit
// - zero limit keeps quiet chopper whenever enable bit is set
// - hold regulation value while other chopper
// - offset seeds limit on quiet re-entry
// - enable bit gates quiet chopper use
// - autoscale bit picks regulation or feed-forward
// - divider code sets pwm period
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module qca_top #(
	parameter int IW = 20
) (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// step pin and current feedback
	input wire logic step_pin,
	input wire logic current_low,
	// chopper outputs
	output logic quiet_active,
	output logic pwm_cycle_start,
	output logic [7:0] pwm_scale
);
	initial begin
		if (IW != 20) $error("qca_top: interval width must be 20");
	end
	qca_pkg::qca_ctrl_t ctrl, next_ctrl;
	qca_pkg::qca_ampl_t ampl, next_ampl;
	logic [19:0] limit, next_limit;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic step_s1, step_s2, step_s3;
	logic [19:0] step_interval;
	logic [9:0] pcount, next_pcount;
	logic next_pwm_cycle_start;
	logic quiet_ok, next_quiet_active;
	logic [7:0] next_pwm_scale;
	logic [7:0] held, next_held;
	logic [31:0] ff_term;
	logic [8:0] ff_sum;
	function automatic logic [9:0] period_of(input logic [1:0] code);
		case (code)
			2'h0: period_of = qca_pkg::period_0;
			2'h1: period_of = qca_pkg::period_1;
			2'h2: period_of = qca_pkg::period_2;
			default: period_of = qca_pkg::period_3;
		endcase
	endfunction
	// step synchroniser and edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_s1 <= 1'b0;
			step_s2 <= 1'b0;
			step_s3 <= 1'b0;
		end else begin
			step_s1 <= step_pin;
			step_s2 <= step_s1;
			step_s3 <= step_s2;
		end
	end
	qca_interval #(.W(20)) u_interval (
		.pclk(pclk),
		.presetn(presetn),
		.step_pulse(step_s2 & ~step_s3),
		.step_interval(step_interval)
	);
	// apb slave, one wait-free access cycle
	always_comb begin
		next_ctrl = ctrl;
		next_ampl = ampl;
		next_limit = limit;
		next_prdata = prdata;
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		if (psel && !penable) begin
			next_pready = 1'b1;
			next_prdata = 32'h0000_0000;
			if (paddr == qca_pkg::reg_ctrl) begin
				next_prdata = {26'h0, ctrl};
			end else if (paddr == qca_pkg::reg_ampl) begin
				next_prdata = {16'h0, ampl};
			end else if (paddr == qca_pkg::reg_limit) begin
				next_prdata = {12'h0, limit};
			end else if (paddr == qca_pkg::reg_status) begin
				next_prdata = {23'h0, quiet_active, pwm_scale};
			end else if (paddr == qca_pkg::reg_interval) begin
				next_prdata = {12'h0, step_interval};
			end else begin
				next_pslverr = 1'b1;
			end
		end
		if (psel && penable && pready && pwrite) begin
			if (paddr == qca_pkg::reg_ctrl) begin
				next_ctrl = pwdata[5:0];
			end else if (paddr == qca_pkg::reg_ampl) begin
				next_ampl = pwdata[15:0];
			end else if (paddr == qca_pkg::reg_limit) begin
				next_limit = pwdata[19:0];
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= '0;
			ampl <= {qca_pkg::gradient_reset, qca_pkg::offset_reset};
			limit <= qca_pkg::limit_reset;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			ampl <= next_ampl;
			limit <= next_limit;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end
	// pwm period divider
	always_comb begin
		next_pwm_cycle_start = 1'b0;
		next_pcount = pcount + 10'h001;
		if (pcount >= period_of(ctrl.chopper_frequency_divider) - 10'h001) begin
			next_pcount = 10'h000;
			next_pwm_cycle_start = 1'b1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pcount <= 10'h000;
			pwm_cycle_start <= 1'b0;
		end else begin
			pcount <= next_pcount;
			pwm_cycle_start <= next_pwm_cycle_start;
		end
	end
	// chopper selection and amplitude
	always_comb begin
		quiet_ok = ctrl.enable;
		if (limit != qca_pkg::limit_reset) begin
			quiet_ok = ctrl.enable && (step_interval >= limit);
		end
		// gradient*256*fstep/fclk, fstep/fclk = 1/interval
		ff_term = ({24'h0, ampl.amplitude_gradient} << 8) / {12'h0, step_interval};
		if (step_interval == 20'h0) begin
			ff_term = 32'h0000_00ff;
		end
		ff_sum = {1'b0, ampl.amplitude_offset} + (ff_term > 32'h0000_00ff ? 9'h0ff : ff_term[8:0]);
		next_quiet_active = quiet_ok;
		next_held = held;
		next_pwm_scale = pwm_scale;
		if (!ctrl.autoscale) begin
			next_pwm_scale = (ff_sum > 9'h0ff) ? qca_pkg::scale_max : ff_sum[7:0];
		end else if (quiet_ok && !quiet_active) begin
			next_pwm_scale = (held < ampl.amplitude_offset) ? held : ampl.amplitude_offset;
		end else if (quiet_ok && pwm_cycle_start) begin
			if (current_low && pwm_scale != qca_pkg::scale_max) begin
				next_pwm_scale = pwm_scale + 8'h01;
			end else if (!current_low && pwm_scale != 8'h00) begin
				next_pwm_scale = pwm_scale - 8'h01;
			end
		end
		if (quiet_active && !quiet_ok) begin
			next_held = pwm_scale;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quiet_active <= 1'b0;
			pwm_scale <= 8'h00;
			held <= qca_pkg::scale_max;
		end else begin
			quiet_active <= next_quiet_active;
			pwm_scale <= next_pwm_scale;
			held <= next_held;
		end
	end
endmodule
`default_nettype wire

/* File: bench/qca_top_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module qca_chk (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// pins
	input wire logic step_pin,
	input wire logic current_low,
	input wire logic quiet_active,
	input wire logic pwm_cycle_start,
	input wire logic [7:0] pwm_scale
);
	logic en, zl, wr, um;
	logic [9:0] gap;
	assign wr = psel && penable && pready && pwrite;
	assign um = paddr > 8'h10 || paddr[1:0] != 2'h0;
	// shadow of enable and zero limit, cycles since pwm start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en <= 1'b0;
			zl <= 1'b1;
			gap <= 10'h3ff;
		end else begin
			if (wr && paddr == 8'h00) en <= pwdata[0];
			if (wr && paddr == 8'h08) zl <= pwdata[19:0] == 20'h0;
			if (wr && paddr == 8'h00) gap <= 10'h3ff;
			else gap <= pwm_cycle_start ? 10'h0 : gap + {9'h0, gap != 10'h3ff};
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready");
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready too long");
	a_err_on_unmapped: assert property (pready |-> pslverr == um) else $error("bad slverr");
	a_unmapped_read_zero: assert property (pready && um && !pwrite |-> prdata == 32'h0)
		else $error("unmapped read data");
	a_off_never_quiet: assert property (!en [*3] |-> !quiet_active) else $error("quiet off");
	a_zero_limit_quiet: assert property ((en && zl) [*3] |-> quiet_active)
		else $error("zero limit left quiet");
	a_start_pulse: assert property (pwm_cycle_start |=> !pwm_cycle_start) else $error("long start");
	a_period_floor: assert property (pwm_cycle_start |-> gap >= 10'h0cc) else $error("short period");
endmodule
bind qca_top qca_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .step_pin(step_pin), .current_low(current_low),
	.quiet_active(quiet_active), .pwm_cycle_start(pwm_cycle_start), .pwm_scale(pwm_scale));
`default_nettype wire

/* File: bench/qca_step_src.sv */
`timescale 1ns/1ns
`default_nettype none
module qca_step_src (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic go,
	input wire logic [19:0] period,
	// step line
	output logic step_pin
);
	logic [19:0] cnt;
	// line low at standstill
	// each start begins from zero velocity
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 20'h0;
			step_pin <= 1'b0;
		end else begin
			cnt <= (!go || cnt >= period - 20'h1) ? 20'h0 : cnt + 20'h1;
			step_pin <= go && cnt < 20'h2;
		end
	end
endmodule
`default_nettype wire

/* File: bench/qca_top_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module qca_top_bench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic current_low = 1'b0;
	logic go = 1'b0;
	logic [19:0] period = 20'h1f4;
	logic [31:0] prdata, rd;
	logic [7:0] pwm_scale;
	logic pready, pslverr, err, step_pin, quiet_active, pwm_cycle_start;
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;
	int off, grad, p, lim, s, i;
	int per[4] = '{32'h200, 32'h156, 32'h100, 32'h0cd};
	always #50 pclk = ~pclk;
	qca_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .step_pin(step_pin), .current_low(current_low),
		.quiet_active(quiet_active), .pwm_cycle_start(pwm_cycle_start), .pwm_scale(pwm_scale));
	qca_step_src src (.pclk(pclk), .presetn(presetn), .go(go), .period(period),
		.step_pin(step_pin));
	task automatic complete_run();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (k == 16) n_mismatch++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// feed-forward amplitude model
	function automatic int ff(int o, int g, int iv);
		int v;
		v = g * 32'h100 / iv;
		v = (v > 32'hff ? 32'hff : v) + o;
		return v > 32'hff ? 32'hff : v;
	endfunction
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 90000) begin
			n_mismatch++;
			complete_run();
		end
	end
	initial begin
		void'($urandom(33));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h04ff);
		apb(1'b1, 8'h14, 32'h5);
		chk({31'h0, err}, 32'h1);
		go <= 1'b1;
		for (i = 0; i < 4; i++) begin
			off = $urandom_range(255);
			grad = $urandom_range(255);
			p = $urandom_range(2000, 200);
			lim = i == 0 ? 0 : i == 1 ? p : p + $urandom_range(200) - 100;
			period <= p[19:0];
			current_low <= $urandom_range(1);
			apb(1'b1, 8'h00, {28'h0, i[1:0], 2'h1});
			apb(1'b1, 8'h04, {16'h0, grad[7:0], off[7:0]});
			apb(1'b1, 8'h08, lim);
			repeat (3 * p) @(posedge pclk);
			apb(1'b0, 8'h10, 32'h0);
			chk(rd, p);
			apb(1'b0, 8'h0c, 32'h0);
			chk(rd, {lim == 0 || p >= lim, 8'(ff(off, grad, p))});
			@(posedge pwm_cycle_start);
			s = cyc;
			@(posedge pwm_cycle_start);
			chk(cyc - s, per[i]);
		end
		apb(1'b1, 8'h00, 32'h0);
		repeat (4) @(posedge pclk);
		apb(1'b0, 8'h0c, 32'h0);
		chk({31'h0, rd[8]}, 32'h0);
		go <= 1'b0;
		apb(1'b1, 8'h00, 32'hf);
		repeat (128) @(posedge pwm_cycle_start);
		period <= 20'h190;
		apb(1'b1, 8'h08, 32'h1f4);
		go <= 1'b1;
		repeat (1200) @(posedge pclk);
		apb(1'b0, 8'h0c, 32'h0);
		chk({31'h0, rd[8]}, 32'h0);
		s = rd[7:0];
		repeat (3) @(posedge pwm_cycle_start);
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd, s);
		off = $urandom_range(255);
		apb(1'b1, 8'h04, {16'h0, 8'h04, off[7:0]});
		@(posedge pwm_cycle_start);
		apb(1'b1, 8'h08, 32'h1);
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd, {1'b1, 8'(s < off ? s : off)});
		complete_run();
	end
endmodule
`default_nettype wire
